//--- logic/dmae_pkg.sv
// Shared constants for the four-channel direct transfer engine.
// Assumes a single system clock and a synchronous active-low reset.
package dmae_pkg;

   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int DMA_NUM_CH = 4;
   localparam int DMA_REGS_PER_CH = 8;
   localparam int DMA_ADDR_W = 24;
   localparam int DMA_CNT_W = 16;
   localparam int DMA_CH_W = 2;

   // ----------------------------------------
   // Channel wiring
   // ----------------------------------------
   // Primary source of channel 0 is reserved, secondary of channel 1 unused
   localparam logic [DMA_NUM_CH-1:0] DMA_PRIM_VALID = 4'hE;
   localparam logic [DMA_NUM_CH-1:0] DMA_SEC_VALID = 4'hD;
   // Set where the engine reads the requesting peripheral (write to addressed device)
   localparam logic [DMA_NUM_CH-1:0] DMA_HW_DIR = 4'h5;

   // ----------------------------------------
   // Item sizes in bytes
   // ----------------------------------------
   localparam int DMA_ITEM_BYTES_8 = 1;
   localparam int DMA_ITEM_BYTES_16 = 2;

   // ----------------------------------------
   // Engine states
   // ----------------------------------------
   typedef enum logic [1:0] {
      DMAE_IDLE,
      DMAE_ARB,
      DMAE_XFER,
      DMAE_TERM
   } dmae_state_e;

endpackage : dmae_pkg

//--- logic/dmae_prio.sv
// Fixed priority picker, lowest index wins.
// Assumes pending bits come from logic on the same clock.
module dmae_prio
   import dmae_pkg::*;
#(
   parameter int NUM_CH = DMA_NUM_CH,
   parameter int CH_W = DMA_CH_W
) (
   input wire logic [NUM_CH-1:0] pending,
   output logic any,
   output logic [CH_W-1:0] winner
);

   // ----------------------------------------
   // Descending scan so channel 0 is taken last
   // ----------------------------------------
   always_comb begin
      any = 1'b0;
      winner = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (pending[i]) begin
            any = 1'b1;
            winner = CH_W'(i);
         end
      end
   end

endmodule : dmae_prio

//--- logic/dmae_chan.sv
// One channel: device-A address counter, block length counter, status.
// Assumes load and step never come in the same cycle.
module dmae_chan
   import dmae_pkg::*;
#(
   parameter int ADDR_W = DMA_ADDR_W,
   parameter int CNT_W = DMA_CNT_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [ADDR_W-1:0] load_addr,
   input wire logic [CNT_W-1:0] load_count,
   input wire logic step,
   input wire logic step_en,
   input wire logic step_down,
   input wire logic size16,
   input wire logic tc_clear,
   output logic [ADDR_W-1:0] addr_r,
   output logic [ADDR_W-1:0] addr_nxt,
   output logic [CNT_W-1:0] count_r,
   output logic last,
   output logic tc_r,
   output logic active_r
);

   logic [ADDR_W-1:0] delta;

   // ----------------------------------------
   // Next address
   // ----------------------------------------
   always_comb begin
      delta = size16 ? ADDR_W'(DMA_ITEM_BYTES_16) : ADDR_W'(DMA_ITEM_BYTES_8);
      addr_nxt = addr_r;
      if (step && step_en) begin
         addr_nxt = step_down ? addr_r - delta : addr_r + delta;
      end
      last = step && (count_r == CNT_W'(1));
   end

   // ----------------------------------------
   // Counters
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addr_r <= '0;
         count_r <= '0;
      end else if (load) begin
         addr_r <= load_addr;
         count_r <= load_count;
      end else if (step) begin
         addr_r <= addr_nxt;
         count_r <= count_r - CNT_W'(1);
      end
   end

   // ----------------------------------------
   // Status, set wins over clear
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tc_r <= 1'b0;
      end else if (last) begin
         tc_r <= 1'b1;
      end else if (tc_clear) begin
         tc_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         active_r <= 1'b0;
      end else if (load) begin
         active_r <= (load_count != '0);
      end else if (last) begin
         active_r <= 1'b0;
      end
   end

endmodule : dmae_chan

//--- logic/dmae_engine.sv
// Four-channel direct (flyby) transfer engine with bus arbitration.
// Assumes requesters, bus arbiter and debug logic share clk.
//
// Functional notes
// - Requests come only from on-chip peripherals or software; no external request.
// - An enabled channel with a request first wins CPU bus mastership.
// - Channel picked one clock before the first bus clock; channel 0 highest.
// - Acknowledge goes to the requester during the bus cycle touching it.
// - On block end: set status, raise interrupt if enabled, then release bus.
// - Continuous policy with request still active runs another cycle, bus kept.
// - Next request sampled when acknowledge drops, then every rising edge.
// - Each channel picks flyby or memory copy; address mode independent of rest.
// - Four channels, 0 to 3, each with eight control registers.
// - Fixed source wiring per channel: serial rx/tx, audio and transcoder data.
// - Flyby moves each item in one bus cycle, never storing data.
// - Flyby never between two memories; one end is a flyby peripheral.
// - Intermittent releases bus after every cycle; continuous keeps it to end.
// - Peak rate: one item per three clocks intermittent, one per clock continuous.
// - The single flyby address comes from the device-A address counter.
// - Software requests: direction clear reads addressed device, set writes it; peripheral requests use DMA_HW_DIR.
// - Item size select picks 8 or 16 bits per flyby cycle.
// - After each item: length counter minus one, address counter stepped.
// - Debug halt pauses all channel activity; resumes when it drops.
module dmae_engine
   import dmae_pkg::*;
#(
   parameter int NUM_CH = DMA_NUM_CH,
   parameter int ADDR_W = DMA_ADDR_W,
   parameter int CNT_W = DMA_CNT_W,
   parameter int CH_W = DMA_CH_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic bus_grant,
   input wire logic debug_halt,
   input wire logic [NUM_CH-1:0] chan_enable,
   input wire logic [NUM_CH-1:0] flyby_mode,
   input wire logic [NUM_CH-1:0] continuous_policy,
   input wire logic [NUM_CH-1:0] direction,
   input wire logic [NUM_CH-1:0] item_size_select,
   input wire logic [NUM_CH-1:0] addr_a_step_enable,
   input wire logic [NUM_CH-1:0] addr_a_step_direction,
   input wire logic [NUM_CH-1:0] primary_src_en,
   input wire logic [NUM_CH-1:0] secondary_src_en,
   input wire logic [NUM_CH-1:0] tc_irq_enable,
   input wire logic [NUM_CH-1:0] sw_request,
   input wire logic [NUM_CH-1:0] primary_req,
   input wire logic [NUM_CH-1:0] secondary_req,
   input wire logic load_strobe,
   input wire logic [CH_W-1:0] load_channel,
   input wire logic [ADDR_W-1:0] load_addr,
   input wire logic [CNT_W-1:0] load_count,
   input wire logic [NUM_CH-1:0] tc_clear,
   output logic bus_req,
   output logic bus_cycle,
   output logic [ADDR_W-1:0] bus_addr,
   output logic bus_write,
   output logic bus_size16,
   output logic [NUM_CH-1:0] ack_primary,
   output logic [NUM_CH-1:0] ack_secondary,
   output logic [NUM_CH-1:0] term_count,
   output logic [NUM_CH-1:0] chan_active,
   output logic [CH_W-1:0] cur_channel,
   output logic irq
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   dmae_state_e state_r;
   dmae_state_e state_nxt;
   logic [NUM_CH-1:0] prim_hit;
   logic [NUM_CH-1:0] sec_hit;
   logic [NUM_CH-1:0] pending;
   logic [NUM_CH-1:0] step_vec;
   logic [NUM_CH-1:0] last_vec;
   logic [NUM_CH-1:0] load_vec;
   logic [ADDR_W-1:0] ch_addr [NUM_CH];
   logic [ADDR_W-1:0] ch_addr_nxt [NUM_CH];
   logic any_pending;
   logic [CH_W-1:0] winner;
   logic [CH_W-1:0] sel_r;
   logic [CH_W-1:0] launch_ch;
   logic launch;
   logic cont_go;
   logic block_end;
   logic bus_req_r;
   logic bus_cycle_r;
   logic [ADDR_W-1:0] bus_addr_r;
   logic bus_write_r;
   logic bus_size16_r;
   logic [NUM_CH-1:0] ack_primary_r;
   logic [NUM_CH-1:0] ack_secondary_r;
   logic irq_r;

   // ----------------------------------------
   // Per-channel request forming and counters
   // ----------------------------------------
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      // Only on-chip sources: wired peripheral lines and software
      assign prim_hit[c] = primary_src_en[c] & primary_req[c] & DMA_PRIM_VALID[c];
      assign sec_hit[c] = secondary_src_en[c] & secondary_req[c] & DMA_SEC_VALID[c];
      // Memory copy channels are left to the indirect path
      assign pending[c] = chan_enable[c] & flyby_mode[c] & chan_active[c]
         & (prim_hit[c] | sec_hit[c] | sw_request[c]);
      assign step_vec[c] = (state_r == DMAE_XFER) && (sel_r == CH_W'(c));
      assign load_vec[c] = load_strobe && (load_channel == CH_W'(c));

      dmae_chan #(
         .ADDR_W(ADDR_W),
         .CNT_W(CNT_W)
      ) u_chan (
         .clk(clk),
         .rst_n(rst_n),
         .load(load_vec[c]),
         .load_addr(load_addr),
         .load_count(load_count),
         .step(step_vec[c]),
         .step_en(addr_a_step_enable[c]),
         .step_down(addr_a_step_direction[c]),
         .size16(item_size_select[c]),
         .tc_clear(tc_clear[c]),
         .addr_r(ch_addr[c]),
         .addr_nxt(ch_addr_nxt[c]),
         .count_r(),
         .last(last_vec[c]),
         .tc_r(term_count[c]),
         .active_r(chan_active[c])
      );
   end

   // ----------------------------------------
   // Fixed priority selection
   // ----------------------------------------
   dmae_prio #(
      .NUM_CH(NUM_CH),
      .CH_W(CH_W)
   ) u_prio (
      .pending(pending),
      .any(any_pending),
      .winner(winner)
   );

   // ----------------------------------------
   // Launch decision
   // ----------------------------------------
   always_comb begin
      block_end = |last_vec;
      // Request seen on the edge that ends the acknowledged cycle
      cont_go = continuous_policy[sel_r] && pending[sel_r] && !debug_halt
         && bus_grant && !block_end;
      launch = 1'b0;
      launch_ch = sel_r;
      if (state_r == DMAE_ARB) begin
         launch = bus_grant && any_pending && !debug_halt;
         launch_ch = winner;
      end else if (state_r == DMAE_XFER) begin
         launch = cont_go;
      end
   end

   // ----------------------------------------
   // State machine
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         DMAE_IDLE: begin
            if (any_pending && !debug_halt) begin
               state_nxt = DMAE_ARB;
            end
         end
         DMAE_ARB: begin
            if (launch) begin
               state_nxt = DMAE_XFER;
            end else if (!any_pending) begin
               state_nxt = DMAE_IDLE;
            end
         end
         DMAE_XFER: begin
            if (block_end) begin
               state_nxt = DMAE_TERM;
            end else if (cont_go) begin
               state_nxt = DMAE_XFER;
            end else begin
               state_nxt = DMAE_IDLE;
            end
         end
         DMAE_TERM: begin
            state_nxt = DMAE_IDLE;
         end
         default: begin
            state_nxt = DMAE_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= DMAE_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------
   // Serviced channel
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sel_r <= '0;
      end else if (launch) begin
         sel_r <= launch_ch;
      end
   end

   // ----------------------------------------
   // Bus request
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bus_req_r <= 1'b0;
      end else begin
         bus_req_r <= (state_nxt == DMAE_ARB) || (state_nxt == DMAE_XFER)
            || (state_nxt == DMAE_TERM);
      end
   end

   // ----------------------------------------
   // Single flyby bus cycle
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bus_cycle_r <= 1'b0;
         bus_addr_r <= '0;
         bus_write_r <= 1'b0;
         bus_size16_r <= 1'b0;
      end else if (launch) begin
         bus_cycle_r <= 1'b1;
         bus_addr_r <= ch_addr_nxt[launch_ch];
         if (prim_hit[launch_ch] || sec_hit[launch_ch]) begin
            bus_write_r <= DMA_HW_DIR[launch_ch];
         end else begin
            bus_write_r <= direction[launch_ch];
         end
         bus_size16_r <= item_size_select[launch_ch];
      end else begin
         bus_cycle_r <= 1'b0;
         bus_addr_r <= '0;
         bus_write_r <= 1'b0;
         bus_size16_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Acknowledge to the implied peripheral
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_primary_r <= '0;
         ack_secondary_r <= '0;
      end else begin
         ack_primary_r <= '0;
         ack_secondary_r <= '0;
         if (launch && prim_hit[launch_ch]) begin
            ack_primary_r[launch_ch] <= 1'b1;
         end else if (launch && sec_hit[launch_ch]) begin
            ack_secondary_r[launch_ch] <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Block-end interrupt
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |((term_count | last_vec) & tc_irq_enable);
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign bus_req = bus_req_r;
   assign bus_cycle = bus_cycle_r;
   assign bus_addr = bus_addr_r;
   assign bus_write = bus_write_r;
   assign bus_size16 = bus_size16_r;
   assign ack_primary = ack_primary_r;
   assign ack_secondary = ack_secondary_r;
   assign cur_channel = sel_r;
   assign irq = irq_r;

endmodule : dmae_engine

//--- test/dmae_engine_asserts.sv
// Port checker for the direct transfer engine.
// Assumes a bind into dmae_engine and one clock domain.
module dmae_engine_asserts
   import dmae_pkg::*;
#(
   parameter int NUM_CH = DMA_NUM_CH,
   parameter int ADDR_W = DMA_ADDR_W,
   parameter int CH_W = DMA_CH_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic bus_grant,
   input wire logic debug_halt,
   input wire logic [NUM_CH-1:0] tc_irq_enable,
   input wire logic bus_req,
   input wire logic bus_cycle,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [NUM_CH-1:0] ack_primary,
   input wire logic [NUM_CH-1:0] ack_secondary,
   input wire logic [NUM_CH-1:0] term_count,
   input wire logic [CH_W-1:0] cur_channel,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [NUM_CH-1:0] ack_any;
   assign ack_any = ack_primary | ack_secondary;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_grant;
      bus_cycle |-> bus_req && $past(bus_grant);
   endproperty
   a_grant: assert property (p_grant) else $error("bus cycle without grant");
   property p_arb_first;
      !bus_req |=> !bus_cycle;
   endproperty
   a_arb_first: assert property (p_arb_first) else $error("cycle before request");
   property p_idle_addr;
      !bus_cycle |-> bus_addr == '0;
   endproperty
   a_idle_addr: assert property (p_idle_addr) else $error("address driven idle");
   property p_ack_cycle;
      |ack_any |-> bus_cycle && $onehot(ack_any);
   endproperty
   a_ack_cycle: assert property (p_ack_cycle) else $error("stray acknowledge");
   property p_ack_chan;
      |ack_any |-> ack_any == (NUM_CH'(1) << cur_channel);
   endproperty
   a_ack_chan: assert property (p_ack_chan) else $error("ack to wrong channel");
   property p_reserved;
      !ack_primary[0] && !ack_secondary[1];
   endproperty
   a_reserved: assert property (p_reserved) else $error("unused source acked");
   property p_halt;
      debug_halt |=> !bus_cycle;
   endproperty
   a_halt: assert property (p_halt) else $error("cycle while halted");
   property p_irq;
      irq == |((term_count | $past(term_count)) & $past(tc_irq_enable));
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");
   property p_release;
      |(term_count & ~$past(term_count)) |=> !bus_req;
   endproperty
   a_release: assert property (p_release) else $error("bus kept after end");
   c_item: cover property (bus_cycle);
   c_burst: cover property (bus_cycle ##1 bus_cycle);
   c_irq: cover property ($rose(irq));
endmodule : dmae_engine_asserts

//--- test/dmae_far.sv
// Far side: CPU bus arbiter and on-chip peripheral requesters.
// Assumes the bench sets item counts through prim_left and sec_left.
module dmae_far
   import dmae_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic bus_req,
   input wire logic [DMA_NUM_CH-1:0] ack_primary,
   input wire logic [DMA_NUM_CH-1:0] ack_secondary,
   output logic bus_grant,
   output logic [DMA_NUM_CH-1:0] primary_req,
   output logic [DMA_NUM_CH-1:0] secondary_req
);
   timeunit 1ns;
   timeprecision 100ps;
   int prim_left[DMA_NUM_CH];
   int sec_left[DMA_NUM_CH];
   int wait_r = 0;
   // ----------------------------------------
   // Arbiter, prompt or three cycles late
   // ----------------------------------------
   always @(posedge clk)
      wait_r <= (rst_n && bus_req) ? wait_r + 1 : 0;
   assign bus_grant = bus_req && wait_r >= (slow ? 3 : 0);
   // Requesters drop the line in the ack cycle of their last item
   always_comb begin
      for (int n = 0; n < DMA_NUM_CH; n++) begin
         primary_req[n] = prim_left[n] > (ack_primary[n] ? 1 : 0);
         secondary_req[n] = sec_left[n] > (ack_secondary[n] ? 1 : 0);
      end
   end
   always @(posedge clk)
      for (int n = 0; n < DMA_NUM_CH; n++) begin
         if (ack_primary[n] && prim_left[n] > 0)
            prim_left[n] <= prim_left[n] - 1;
         if (ack_secondary[n] && sec_left[n] > 0)
            sec_left[n] <= sec_left[n] - 1;
      end
endmodule : dmae_far

//--- test/dmae_engine_tb.sv
// Self-checking bench for the direct transfer engine.
// Assumes one source enabled per channel, flyby ends only.
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %s exp %0h got %0h", n, e, g); end end
module dmae_engine_tb
   import dmae_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_n, debug_halt, load_strobe, slow, bus_grant;
   logic [3:0] chan_enable, flyby_mode, continuous_policy, direction, item_size_select;
   logic [3:0] addr_a_step_enable, addr_a_step_direction, primary_src_en, secondary_src_en;
   logic [3:0] tc_irq_enable, sw_request, primary_req, secondary_req, tc_clear;
   logic [1:0] load_channel, cur_channel;
   logic [23:0] load_addr, bus_addr;
   logic [15:0] load_count;
   logic bus_req, bus_cycle, bus_write, bus_size16, irq;
   logic [3:0] ack_primary, ack_secondary, term_count, chan_active;
   int failures = 0;
   int checked = 0;
   int cyc = 0;
   dmae_engine i_dut (.clk, .rst_n, .bus_grant, .debug_halt, .chan_enable, .flyby_mode,
      .continuous_policy, .direction, .item_size_select, .addr_a_step_enable,
      .addr_a_step_direction, .primary_src_en, .secondary_src_en, .tc_irq_enable,
      .sw_request, .primary_req, .secondary_req, .load_strobe, .load_channel, .load_addr,
      .load_count, .tc_clear, .bus_req, .bus_cycle, .bus_addr, .bus_write, .bus_size16,
      .ack_primary, .ack_secondary, .term_count, .chan_active, .cur_channel, .irq);
   dmae_far i_far (.clk, .rst_n, .slow, .bus_req, .ack_primary, .ack_secondary,
      .bus_grant, .primary_req, .secondary_req);
   always @(posedge clk)
      cyc <= cyc + 1;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic tick();
      @(posedge clk);
      #2;
   endtask : tick
   task automatic clear();
      {chan_enable, continuous_policy, direction, item_size_select, addr_a_step_enable,
         addr_a_step_direction, primary_src_en, secondary_src_en, tc_irq_enable,
         sw_request, debug_halt, slow} = '0;
      flyby_mode = 4'hF;
      tc_clear = 4'hF;
      tick();
      tc_clear = 4'h0;
   endtask : clear
   task automatic load(input int ch, input logic [23:0] a, input logic [15:0] n);
      load_strobe = 1'b1;
      load_channel = 2'(ch);
      load_addr = a;
      load_count = n;
      tick();
      load_strobe = 1'b0;
      tick();
   endtask : load
   task automatic watch(input int ch, input int n, input logic [23:0] a0, input int stp,
      input bit wr, input bit s16, input bit hw, input bit sec, input int gap);
      logic [23:0] ea;
      logic [3:0] eack;
      int t;
      int last;
      bit low;
      ea = a0;
      eack = hw ? 4'h1 << ch : 4'h0;
      last = 0;
      for (int i = 0; i < n; i++) begin
         t = 0;
         low = 0;
         while (bus_cycle !== 1'b1 && t < 60) begin
            if (bus_req === 1'b0)
               low = 1;
            tick();
            t++;
         end
         if (i > 0 && gap > 0) begin
            `CHK("gap", gap, cyc - last)
            `CHK("release", gap == 3, low)
         end
         last = cyc;
         `CHK("cycle", 1'b1, bus_cycle)
         `CHK("addr", ea, bus_addr)
         `CHK("write", wr, bus_write)
         `CHK("size", s16, bus_size16)
         `CHK("chan", 2'(ch), cur_channel)
         `CHK("ackp", sec ? 4'h0 : eack, ack_primary)
         `CHK("acks", sec ? eack : 4'h0, ack_secondary)
         ea = ea + 24'(stp);
         tick();
      end
      `CHK("tc", 1'b1, term_count[ch])
      `CHK("active", 1'b0, chan_active[ch])
   endtask : watch
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_intermittent();
      clear();
      {chan_enable, primary_src_en, item_size_select} = {4'h4, 4'h4, 4'h4};
      {addr_a_step_enable, tc_irq_enable} = {4'h4, 4'h4};
      load(2, 24'h001000, 16'h0003);
      i_far.prim_left[2] = 3;
      watch(2, 3, 24'h001000, 2, DMA_HW_DIR[2], 1'b1, 1'b1, 1'b0, 3);
      tick();
      `CHK("req", 1'b0, bus_req)
      `CHK("irq", 1'b1, irq)
      tc_clear = 4'h4;
      tick();
      tc_clear = 4'h0;
      tick();
      `CHK("clr", 1'b0, term_count[2])
   endtask : t_intermittent
   task automatic t_continuous();
      clear();
      {chan_enable, secondary_src_en, continuous_policy} = {4'h8, 4'h8, 4'h8};
      {addr_a_step_enable, addr_a_step_direction} = {4'h8, 4'h8};
      load(3, 24'h0020FF, 16'h0004);
      i_far.sec_left[3] = 4;
      watch(3, 4, 24'h0020FF, -1, DMA_HW_DIR[3], 1'b0, 1'b1, 1'b1, 1);
   endtask : t_continuous
   task automatic t_priority();
      int t0;
      clear();
      slow = 1'b1;
      {chan_enable, primary_src_en, addr_a_step_enable} = {4'hA, 4'hA, 4'hA};
      load(1, 24'h003000, 16'h0001);
      load(3, 24'h004000, 16'h0001);
      i_far.prim_left[1] = 1;
      i_far.prim_left[3] = 1;
      t0 = cyc;
      watch(1, 1, 24'h003000, 1, DMA_HW_DIR[1], 1'b0, 1'b1, 1'b0, 0);
      `CHK("arb", 1'b1, cyc - t0 > 3)
      watch(3, 1, 24'h004000, 1, DMA_HW_DIR[3], 1'b0, 1'b1, 1'b0, 0);
   endtask : t_priority
   task automatic t_halt_sw();
      clear();
      {chan_enable, direction, debug_halt} = {4'h2, 4'h2, 1'b1};
      load(1, 24'h005000, 16'h0002);
      sw_request = 4'h2;
      repeat (8) begin
         tick();
         `CHK("halt", 1'b0, bus_req | bus_cycle)
      end
      debug_halt = 1'b0;
      watch(1, 2, 24'h005000, 0, 1'b1, 1'b0, 1'b0, 1'b0, 3);
      sw_request = 4'h0;
   endtask : t_halt_sw
   task automatic t_gate();
      clear();
      {chan_enable, secondary_src_en, flyby_mode} = {4'h1, 4'h1, 4'hE};
      load(0, 24'h006000, 16'h0001);
      i_far.sec_left[0] = 1;
      for (int k = 0; k < 2; k++) begin
         repeat (10) tick();
         `CHK("gate", 1'b0, bus_req)
         flyby_mode = 4'hF;
         chan_enable = 4'h0;
      end
      chan_enable = 4'h1;
      watch(0, 1, 24'h006000, 0, DMA_HW_DIR[0], 1'b0, 1'b1, 1'b1, 0);
   endtask : t_gate
   task automatic print_verdict();
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      print_verdict();
   end
   initial begin
      {rst_n, load_strobe, load_channel, load_addr, load_count, tc_clear} = '0;
      {chan_enable, continuous_policy, direction, item_size_select, addr_a_step_enable,
         addr_a_step_direction, primary_src_en, secondary_src_en, tc_irq_enable,
         sw_request, debug_halt, slow} = '0;
      flyby_mode = 4'hF;
      repeat (12) @(posedge clk);
      #2;
      rst_n = 1'b1;
      tick();
      t_intermittent();
      t_continuous();
      t_priority();
      t_halt_sw();
      t_gate();
      print_verdict();
   end
endmodule : dmae_engine_tb
bind dmae_engine dmae_engine_asserts #(.NUM_CH(NUM_CH), .ADDR_W(ADDR_W), .CH_W(CH_W)) i_chk (
   .clk, .rst_n, .bus_grant, .debug_halt, .tc_irq_enable, .bus_req, .bus_cycle, .bus_addr,
   .ack_primary, .ack_secondary, .term_count, .cur_channel, .irq);
